/* File: timer0_pkg.sv */
// How it works
// - Clock source select clear: timer mode, one count per instruction cycle.
// - A write to the counter blocks counting for the next two cycles.
// - Source select set: count pin edges; edge select clear rising, set falling.
// - Assign bit clear gives prescaler to timer, set gives it to watchdog.
// - Prescaler divides count source by 1:2 up to 1:256, powers of two.
// - Rollover FFh to 00h sets overflow flag at control bit 2.
// - Interrupt request only while enable bit 5 is set.
// - Flag never self clears; only a software write clears it.
// - Timer stops in sleep, so overflow cannot wake the core.
// - Flag sets on the rollover edge; count shows 00h three periods later.
// - Flag sampled once per instruction cycle in Q1.
// - Prescaler output sampled in phases Q2 and Q4 to synchronise it.
// - Count increments three to seven periods after an input change.
// - Counter writes clear the prescaler while it serves the timer.
// - Watchdog clear resets the prescaler while it serves the watchdog.
// - Software has no read or write path to the prescaler.
// - Prescaler feeds one user; the other runs undivided.
package timer0_pkg;
    localparam logic [7:0] ADDR_TIMER_COUNT = 8'h01;
    localparam logic [7:0] ADDR_INT_CONTROL = 8'h0b;
    localparam logic [7:0] ADDR_OPTION      = 8'h81;
    localparam logic [7:0] ADDR_PORT_A_DIR  = 8'h85;
    localparam logic [7:0] OPTION_RESET     = 8'hff;
    localparam logic [7:0] INT_CTRL_RESET   = 8'h00;
    localparam logic [7:0] PORT_A_DIR_RESET = 8'h1f;
    localparam logic [7:0] PORT_A_DIR_MASK  = 8'h1f;
    localparam int BIT_CLOCK_SOURCE   = 5;
    localparam int BIT_SOURCE_EDGE    = 4;
    localparam int BIT_PRESCALER_ASGN = 3;
    localparam int BIT_RATIO_HI       = 2;
    localparam int BIT_OVF_ENABLE     = 5;
    localparam int BIT_OVF_FLAG       = 2;
    localparam int PHASES_PER_CYCLE   = 4;
    localparam int INHIBIT_CYCLES     = 2;
    localparam int ROLL_DELAY_TOSC    = 3;
    localparam logic [1:0] PHASE_Q1 = 2'h0;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;
endpackage

/* File: timer0_core.sv */
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module timer0_core (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire timer0_pkg::reg_req_t req_i,
    output logic [7:0]             rdata_o,
    input  wire logic              ext_count_pin_i,
    input  wire logic              sleep_i,
    input  wire logic              watchdog_clear_instr_i,
    input  wire logic              watchdog_tick_i,
    output logic                   watchdog_tick_o,
    output logic                   timer_irq_o,
    output logic                   q1_sample_o
);
    import timer0_pkg::*;

    // ************************************************
    // Phase clock
    // ************************************************
    // Core clock is the oscillator; four phases per instruction cycle
    logic [1:0] phase_reg;
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            phase_reg <= PHASE_Q1;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    // ************************************************
    // Registers
    // ************************************************
    logic [7:0] option_reg;
    logic [7:0] port_a_dir_reg;
    logic       overflow_int_enable_reg;
    logic       overflow_flag_reg;
    logic [7:0] int_other_reg;
    logic       clock_source_select;
    logic       source_edge_select;
    logic       prescaler_assign;
    logic [2:0] prescale_ratio;
    logic       wr_count;

    assign clock_source_select = option_reg[BIT_CLOCK_SOURCE];
    assign source_edge_select  = option_reg[BIT_SOURCE_EDGE];
    assign prescaler_assign    = option_reg[BIT_PRESCALER_ASGN];
    assign prescale_ratio      = option_reg[BIT_RATIO_HI:0];
    assign wr_count = req_i.wr && (req_i.addr == ADDR_TIMER_COUNT);

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            option_reg     <= OPTION_RESET;
            port_a_dir_reg <= PORT_A_DIR_RESET;
        end else if (req_i.wr && req_i.addr == ADDR_OPTION) begin
            option_reg <= req_i.wdata;
        end else if (req_i.wr && req_i.addr == ADDR_PORT_A_DIR) begin
            port_a_dir_reg <= req_i.wdata & PORT_A_DIR_MASK;
        end
    end

    // Other control bits are plain storage here
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            int_other_reg           <= INT_CTRL_RESET;
            overflow_int_enable_reg <= 1'b0;
        end else if (req_i.wr && req_i.addr == ADDR_INT_CONTROL) begin
            int_other_reg           <= req_i.wdata;
            overflow_int_enable_reg <= req_i.wdata[BIT_OVF_ENABLE];
        end
    end

    // ************************************************
    // External input synchroniser
    // ************************************************
    logic pin_meta_reg;
    logic pin_sync_reg;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= ext_count_pin_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Edge picked after the history flop, so flipping the select
    // never fakes an edge; a pin held high out of reset gives one rising edge
    logic src_level_reg;
    logic ext_edge;
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            src_level_reg <= 1'b0;
        else
            src_level_reg <= pin_sync_reg;
    end
    assign ext_edge = source_edge_select
                    ? (!pin_sync_reg && src_level_reg)
                    : (pin_sync_reg && !src_level_reg);

    // ************************************************
    // Shared prescaler
    // ************************************************
    logic       cycle_tick;
    logic       count_src;
    logic       wdt_src;
    logic       pre_in;
    logic [7:0] prescaler_reg;
    logic [7:0] prescaler_next;
    logic       pre_out_level;

    assign cycle_tick = (phase_reg == PHASE_Q1) && !sleep_i;
    assign count_src  = clock_source_select ? ext_edge : cycle_tick;
    assign wdt_src    = watchdog_tick_i;
    // One user at a time; the other bypasses the counter
    assign pre_in = prescaler_assign ? wdt_src : count_src;
    assign prescaler_next = prescaler_reg + 8'h01;

    // No bus path reaches this counter; only clears affect it
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            prescaler_reg <= 8'h00;
        else if (!prescaler_assign && wr_count)
            prescaler_reg <= 8'h00;
        else if (prescaler_assign && watchdog_clear_instr_i)
            prescaler_reg <= 8'h00;
        else if (pre_in)
            prescaler_reg <= prescaler_next;
    end

    // Bit k toggles at 1:2^(k+1); its level is the symmetric output
    assign pre_out_level = prescaler_reg[prescale_ratio];

    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            watchdog_tick_o <= 1'b0;
        else if (prescaler_assign)
            watchdog_tick_o <= pre_in && (prescaler_next[prescale_ratio]
                               && !prescaler_reg[prescale_ratio]);
        else
            watchdog_tick_o <= wdt_src;
    end

    // ************************************************
    // Q2/Q4 sampling of the count clock
    // ************************************************
    // Sampling adds the documented 3..7 Tosc uncertainty
    logic timer_level;
    logic sample_reg;
    logic sample_prev_reg;
    logic timer_clk_edge;
    logic direct_pulse_reg;
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            direct_pulse_reg <= 1'b0;
        else if (count_src)
            direct_pulse_reg <= ~direct_pulse_reg;
    end
    // Without prescaler a toggle carries each source event
    assign timer_level = prescaler_assign ? direct_pulse_reg : pre_out_level;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sample_reg      <= 1'b0;
            sample_prev_reg <= 1'b0;
        end else if (phase_reg == PHASE_Q2 || phase_reg == PHASE_Q4) begin
            sample_reg      <= timer_level;
            sample_prev_reg <= sample_reg;
        end
    end
    assign timer_clk_edge = (phase_reg == PHASE_Q2 || phase_reg == PHASE_Q4)
                          && (sample_reg != sample_prev_reg)
                          && (prescaler_assign || sample_reg);

    // ************************************************
    // Counter
    // ************************************************
    logic [7:0] timer_count_reg;
    logic [1:0] inhibit_reg;
    logic [1:0] roll_reg;
    logic       roll_pending_reg;

    // Write inhibit counts whole instruction cycles
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            inhibit_reg <= 2'h0;
        else if (wr_count)
            inhibit_reg <= 2'(INHIBIT_CYCLES);
        else if (phase_reg == PHASE_Q1 && inhibit_reg != 2'h0)
            inhibit_reg <= inhibit_reg - 2'h1;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            timer_count_reg  <= 8'h00;
            roll_reg         <= 2'h0;
            roll_pending_reg <= 1'b0;
        end else if (wr_count) begin
            timer_count_reg  <= req_i.wdata;
            roll_pending_reg <= 1'b0;
        end else if (roll_pending_reg) begin
            if (roll_reg == 2'h1) begin
                timer_count_reg  <= 8'h00;
                roll_pending_reg <= 1'b0;
            end
            roll_reg <= roll_reg - 2'h1;
        end else if (timer_clk_edge && inhibit_reg == 2'h0 && !sleep_i) begin
            if (timer_count_reg == 8'hff) begin
                roll_pending_reg <= 1'b1;
                roll_reg         <= 2'(ROLL_DELAY_TOSC);
            end else begin
                timer_count_reg <= timer_count_reg + 8'h01;
            end
        end
    end

    // ************************************************
    // Overflow flag and request
    // ************************************************
    logic set_flag;
    assign set_flag = timer_clk_edge && inhibit_reg == 2'h0 && !sleep_i
                    && !wr_count && !roll_pending_reg
                    && timer_count_reg == 8'hff;

    // Set beats a same-cycle software clear
    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            overflow_flag_reg <= 1'b0;
        else if (set_flag)
            overflow_flag_reg <= 1'b1;
        else if (req_i.wr && req_i.addr == ADDR_INT_CONTROL)
            overflow_flag_reg <= req_i.wdata[BIT_OVF_FLAG];
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            timer_irq_o <= 1'b0;
            q1_sample_o <= 1'b0;
        end else begin
            q1_sample_o <= phase_reg == PHASE_Q1;
            if (phase_reg == PHASE_Q1)
                timer_irq_o <= overflow_flag_reg
                               && overflow_int_enable_reg;
        end
    end

    // ************************************************
    // Read port
    // ************************************************
    logic [7:0] int_view;
    always_comb begin
        int_view = int_other_reg;
        int_view[BIT_OVF_ENABLE] = overflow_int_enable_reg;
        int_view[BIT_OVF_FLAG]   = overflow_flag_reg;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i)
            rdata_o <= 8'h00;
        else if (req_i.rd) begin
            case (req_i.addr)
                ADDR_TIMER_COUNT: rdata_o <= timer_count_reg;
                ADDR_INT_CONTROL: rdata_o <= int_view;
                ADDR_OPTION:      rdata_o <= option_reg;
                ADDR_PORT_A_DIR:  rdata_o <= port_a_dir_reg;
                default:          rdata_o <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: timer0_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// Port checker for the timer core
// ************************************************
module timer0_monitor (
    input wire logic                 clk_i,
    input wire logic                 rstn_i,
    input wire timer0_pkg::reg_req_t req_i,
    input wire logic [7:0]           rdata_o,
    input wire logic                 sleep_i,
    input wire logic                 watchdog_tick_i,
    input wire logic                 watchdog_tick_o,
    input wire logic                 timer_irq_o,
    input wire logic                 q1_sample_o
);
    import timer0_pkg::*;
    logic [7:0] opt_q;
    logic       en_q;
    logic       flag_q;
    logic       rdi_q;
    logic       mapped;
    logic       wr_ic;
    assign mapped = req_i.addr inside {ADDR_TIMER_COUNT, ADDR_INT_CONTROL,
                                       ADDR_OPTION, ADDR_PORT_A_DIR};
    assign wr_ic = req_i.wr && req_i.addr == ADDR_INT_CONTROL;
    // Shadow of what software wrote, kept beside the design
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            opt_q <= OPTION_RESET;
            en_q <= 1'b0;
        end else if (req_i.wr && req_i.addr == ADDR_OPTION) begin
            opt_q <= req_i.wdata;
        end else if (wr_ic) begin
            en_q <= req_i.wdata[BIT_OVF_ENABLE];
        end
    end
    // Flag once read as set must read set until software writes
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdi_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            rdi_q <= req_i.rd && req_i.addr == ADDR_INT_CONTROL;
            if (wr_ic) begin
                flag_q <= 1'b0;
            end else if (rdi_q && rdata_o[BIT_OVF_FLAG]) begin
                flag_q <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    q1_period_a: assert property (
        q1_sample_o |=> !q1_sample_o [*3] ##1 q1_sample_o)
        else $error("q1 spacing wrong");
    unmapped_read_a: assert property (
        req_i.rd && !mapped |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    option_read_a: assert property (
        req_i.rd && req_i.addr == ADDR_OPTION |=> rdata_o == opt_q)
        else $error("option readback wrong");
    count_hold_a: assert property (
        req_i.wr && req_i.addr == ADDR_TIMER_COUNT ##2
        req_i.rd && req_i.addr == ADDR_TIMER_COUNT
        |=> rdata_o == $past(req_i.wdata, 3)) else $error("count moved");
    wdog_pass_a: assert property (
        !opt_q[BIT_PRESCALER_ASGN] |=> watchdog_tick_o == $past(watchdog_tick_i))
        else $error("watchdog tick not passed");
    irq_mask_a: assert property (
        !en_q [*6] |-> !timer_irq_o) else $error("masked irq seen");
    sleep_irq_a: assert property (
        (sleep_i && !req_i.wr) [*8] |-> !$rose(timer_irq_o))
        else $error("irq rose in sleep");
    flag_stick_a: assert property (
        rdi_q && flag_q |-> rdata_o[BIT_OVF_FLAG]) else $error("flag lost");
    irq_c: cover property ($rose(timer_irq_o));
    wdog_c: cover property (watchdog_tick_o);
    sleep_c: cover property (sleep_i [*8]);
endmodule
bind timer0_core timer0_monitor mon_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .rdata_o(rdata_o),
    .sleep_i(sleep_i), .watchdog_tick_i(watchdog_tick_i),
    .watchdog_tick_o(watchdog_tick_o), .timer_irq_o(timer_irq_o),
    .q1_sample_o(q1_sample_o));
`default_nettype wire

/* File: ext_count_source.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// External count source on the pin
// ************************************************
module ext_count_source (
    input  wire logic clk_i,
    output logic      pin_o
);
    initial pin_o = 1'b0;
    // Caller holds each level two clocks or more
    task automatic set_level(input logic v, input int hold);
        pin_o <= v;
        repeat (hold) @(posedge clk_i);
    endtask
    // Period of six clocks, above four clocks over the ratio
    task automatic burst(input int n);
        repeat (n) begin
            set_level(1'b1, 3);
            set_level(1'b0, 3);
        end
    endtask
endmodule
`default_nettype wire

/* File: timer0_with_shared_prescaler_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// Scenarios
// ************************************************
module timer0_with_shared_prescaler_bench;
    import timer0_pkg::*;
    logic clk_i, rstn_i, sleep_i, wdc, wdt, wdo, irq, q1, pin;
    reg_req_t req;
    logic [7:0] rdata, v1, v2;
    int fails, compares, i, n;
    timer0_core dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req),
        .rdata_o(rdata), .ext_count_pin_i(pin), .sleep_i(sleep_i),
        .watchdog_clear_instr_i(wdc), .watchdog_tick_i(wdt),
        .watchdog_tick_o(wdo), .timer_irq_o(irq), .q1_sample_o(q1));
    ext_count_source src_u (.clk_i(clk_i), .pin_o(pin));
    task automatic chk(input string nm, input logic [7:0] s, e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, d);
        req <= '{a, d, 1'b1, 1'b0};
        tick(1);
        req <= '0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        tick(1);
        req <= '0;
        #1 v = rdata;
        tick(1);
    endtask
    task automatic rc(input logic [7:0] a, e);
        rd(a, v1);
        chk("rdata", v1, e);
    endtask
    task automatic wdclr;
        wdc <= 1'b1;
        tick(1);
        wdc <= 1'b0;
        tick(1);
    endtask
    task automatic wrap_up;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic t_regs;
        rc(ADDR_OPTION, OPTION_RESET);
        rc(ADDR_TIMER_COUNT, 8'h00);
        wr(8'h3c, 8'h55);
        rc(8'h3c, 8'h00);
        wr(ADDR_PORT_A_DIR, 8'hff);
        rc(ADDR_PORT_A_DIR, 8'h1f);
    endtask
    task automatic t_timer;
        wr(ADDR_OPTION, 8'hc8);
        wr(ADDR_TIMER_COUNT, 8'h40);
        rc(ADDR_TIMER_COUNT, 8'h40);
        tick(10);
        rd(ADDR_TIMER_COUNT, v2);
        tick(38);
        rd(ADDR_TIMER_COUNT, v1);
        chk("step", v1 - v2, 8'h0a);
        sleep_i <= 1'b1;
        tick(4);
        rd(ADDR_TIMER_COUNT, v2);
        tick(40);
        rc(ADDR_TIMER_COUNT, v2);
        sleep_i <= 1'b0;
    endtask
    task automatic t_ovf;
        wr(ADDR_INT_CONTROL, 8'h20);
        wr(ADDR_TIMER_COUNT, 8'hfe);
        for (i = 0; i < 60 && irq !== 1'b1; i++) @(negedge clk_i);
        if (i == 60) begin
            fails++;
            wrap_up();
        end
        tick(1);
        rc(ADDR_INT_CONTROL, 8'h24);
        rc(ADDR_INT_CONTROL, 8'h24);
        wr(ADDR_INT_CONTROL, 8'h04);
        tick(8);
        chk("irq", {7'h0, irq}, 8'h00);
        rc(ADDR_INT_CONTROL, 8'h04);
        wr(ADDR_INT_CONTROL, 8'h00);
        rc(ADDR_INT_CONTROL, 8'h00);
    endtask
    task automatic t_prescale;
        wdclr();
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_OPTION, {5'h18, k[2:0]});
            wr(ADDR_TIMER_COUNT, 8'h00);
            tick(12);
            rd(ADDR_TIMER_COUNT, v2);
            tick((32 << k) - 2);
            rd(ADDR_TIMER_COUNT, v1);
            chk("ratio", v1 - v2, 8'h04);
        end
        // Late counter write must also drop the partial prescale
        wr(ADDR_TIMER_COUNT, 8'h00);
        tick(400);
        wr(ADDR_TIMER_COUNT, 8'h00);
        tick(400);
        rc(ADDR_TIMER_COUNT, 8'h00);
    endtask
    task automatic t_ext;
        wr(ADDR_OPTION, 8'he8);
        wr(ADDR_TIMER_COUNT, 8'h00);
        tick(10);
        src_u.set_level(1'b1, 0);
        rc(ADDR_TIMER_COUNT, 8'h00);
        tick(5);
        rc(ADDR_TIMER_COUNT, 8'h01);
        src_u.set_level(1'b0, 10);
        rc(ADDR_TIMER_COUNT, 8'h01);
        wr(ADDR_OPTION, 8'hf8);
        src_u.set_level(1'b1, 10);
        rc(ADDR_TIMER_COUNT, 8'h01);
        src_u.set_level(1'b0, 10);
        rc(ADDR_TIMER_COUNT, 8'h02);
        wdclr();
        wr(ADDR_OPTION, 8'he0);
        wr(ADDR_TIMER_COUNT, 8'h00);
        tick(12);
        src_u.burst(8);
        tick(10);
        rc(ADDR_TIMER_COUNT, 8'h04);
    endtask
    task automatic t_wdog;
        wr(ADDR_OPTION, 8'hc0);
        wdt <= 1'b1;
        tick(1);
        wdt <= 1'b0;
        #1 chk("wdog", {7'h0, wdo}, 8'h01);
        tick(1);
        wr(ADDR_TIMER_COUNT, 8'h00);
        wdclr();
        wr(ADDR_OPTION, 8'hc8);
        wdclr();
        n = 0;
        repeat (4) begin
            wdt <= 1'b1;
            tick(1);
            wdt <= 1'b0;
            #1 n += wdo;
            tick(1);
        end
        chk("wdog", n[7:0], 8'h02);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        {rstn_i, sleep_i, wdc, wdt} = 4'h0;
        req = '0;
        fails = 0;
        compares = 0;
        tick(6);
        rstn_i <= 1'b1;
        tick(1);
        t_regs();
        t_timer();
        t_ovf();
        t_prescale();
        t_ext();
        t_wdog();
        wrap_up();
    end
endmodule
`default_nettype wire
